// [hdl/gmc_top.sv]
// motion mode control: sample timing, entry and exit, fifo level, interrupt and flags
`include "gmc_defs.svh"

module gmc_top #(
  parameter int unsigned UNIT_CYC   = `GMC_UNIT_CYC,
  parameter int unsigned FIFO_DEPTH = 32
) (
  // clock and reset
  input  wire logic              CLK_SYS_I,
  input  wire logic              RST_I,
  // register port
  input  wire logic [7:0]        REG_ADDR_I,
  input  wire logic              REG_WR_I,
  input  wire gmc_pkg::gmc_byte_t REG_WDATA_I,
  input  wire logic              REG_RD_I,
  output gmc_pkg::gmc_byte_t     REG_RDATA_O,
  // configuration from neighbouring registers
  input  wire logic              ENGINE_EN_I,
  input  wire logic [1:0]        EXIT_PERSIST_I,
  input  wire logic [3:0]        EXIT_IGNORE_I,
  input  wire logic [1:0]        FIFO_IRQ_LEVEL_I,
  // proximity and dataset engine
  input  wire logic              PROX_VALID_I,
  input  wire gmc_pkg::gmc_word_t PROX_RESULT_I,
  input  wire logic              CONV_BUSY_I,
  input  wire logic              DSET_VALID_I,
  input  wire gmc_pkg::gmc_word_t CH_NORTH_I,
  input  wire gmc_pkg::gmc_word_t CH_SOUTH_I,
  input  wire gmc_pkg::gmc_word_t CH_WEST_I,
  input  wire gmc_pkg::gmc_word_t CH_EAST_I,
  input  wire logic              DSET_READ_I,
  // status and control outputs
  output logic                   SAMPLE_TICK_O,
  output logic                   FIFO_PUSH_O,
  output logic                   MOTION_MODE_O,
  output logic                   MOTION_IRQ_O,
  output logic                   FIFO_VALID_O,
  output logic                   FIFO_OVERFLOW_O
);
  import gmc_pkg::*;

  localparam int PW = 20;

  // ========================================================================================
  // register file
  gmc_byte_t  period_r;
  logic       irq_en_r;
  gmc_word_t  entry_thr_r;
  gmc_word_t  exit_thr_r;
  gmc_byte_t  level_r;
  gmc_byte_t  level_nxt;
  gmc_state_t state_r;
  logic       wr_ctrl;
  logic       in_mode;

  assign wr_ctrl = REG_WR_I && (REG_ADDR_I == `GMC_OFS_CONTROL);
  assign in_mode = (state_r != GMC_IDLE);

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      period_r    <= `GMC_RST_SAMPLE_PERIOD;
      irq_en_r    <= 1'b0;
      entry_thr_r <= {`GMC_RST_BYTE, `GMC_RST_BYTE};
      exit_thr_r  <= {`GMC_RST_BYTE, `GMC_RST_BYTE};
    end else if (REG_WR_I) begin
      unique case (REG_ADDR_I)
        `GMC_OFS_SAMPLE_PERIOD: period_r          <= REG_WDATA_I;
        `GMC_OFS_CONTROL:       irq_en_r          <= REG_WDATA_I[`GMC_BIT_IRQ_EN];
        `GMC_OFS_ENTRY_LO:      entry_thr_r[7:0]  <= REG_WDATA_I;
        `GMC_OFS_ENTRY_HI:      entry_thr_r[15:8] <= REG_WDATA_I;
        `GMC_OFS_EXIT_LO:       exit_thr_r[7:0]   <= REG_WDATA_I;
        `GMC_OFS_EXIT_HI:       exit_thr_r[15:8]  <= REG_WDATA_I;
        default: ;
      endcase
    end
  end

  // ========================================================================================
  // read data, registered on the read strobe
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      REG_RDATA_O <= `GMC_RST_BYTE;
    end else if (REG_RD_I) begin
      unique case (REG_ADDR_I)
        `GMC_OFS_SAMPLE_PERIOD: REG_RDATA_O <= period_r;
        `GMC_OFS_CONTROL:       REG_RDATA_O <= {6'h00, irq_en_r, in_mode};
        `GMC_OFS_ENTRY_LO:      REG_RDATA_O <= entry_thr_r[7:0];
        `GMC_OFS_ENTRY_HI:      REG_RDATA_O <= entry_thr_r[15:8];
        `GMC_OFS_EXIT_LO:       REG_RDATA_O <= exit_thr_r[7:0];
        `GMC_OFS_EXIT_HI:       REG_RDATA_O <= exit_thr_r[15:8];
        `GMC_OFS_FIFO_LEVEL:    REG_RDATA_O <= level_r;
        default:                REG_RDATA_O <= `GMC_RD_UNMAPPED;
      endcase
    end
  end

  // ========================================================================================
  // sample period timer; the setting is sampled at each tick, so a new value
  // takes effect from the next period onward
  logic [PW-1:0] per_cnt_r;
  logic [PW-1:0] per_load;
  logic          tick;

  // period of unit times setting plus one
  assign per_load = PW'((32'(period_r) + 32'd1) * UNIT_CYC - 32'd1);
  assign tick     = (state_r == GMC_ACTIVE) && (per_cnt_r == '0);

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      per_cnt_r <= '0;
    end else if (state_r != GMC_ACTIVE) begin
      per_cnt_r <= '0;
    end else if (tick) begin
      per_cnt_r <= per_load;
    end else begin
      per_cnt_r <= per_cnt_r - PW'(1);
    end
  end

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      SAMPLE_TICK_O <= 1'b0;
    end else begin
      SAMPLE_TICK_O <= tick;
    end
  end

  // ========================================================================================
  // entry and exit decisions
  logic       entry_hit;
  logic       below_all;
  logic [3:0] need_hits;
  logic [3:0] hits_r;
  logic       exit_hit;

  assign entry_hit = ENGINE_EN_I && PROX_VALID_I && (PROX_RESULT_I > entry_thr_r);

  assign below_all = (EXIT_IGNORE_I[0] || (CH_NORTH_I < exit_thr_r)) &&
                     (EXIT_IGNORE_I[1] || (CH_SOUTH_I < exit_thr_r)) &&
                     (EXIT_IGNORE_I[2] || (CH_WEST_I  < exit_thr_r)) &&
                     (EXIT_IGNORE_I[3] || (CH_EAST_I  < exit_thr_r));

  always_comb begin
    unique case (EXIT_PERSIST_I)
      2'd0: need_hits = `GMC_PERSIST_0;
      2'd1: need_hits = `GMC_PERSIST_1;
      2'd2: need_hits = `GMC_PERSIST_2;
      2'd3: need_hits = `GMC_PERSIST_3;
    endcase
  end

  assign exit_hit = (state_r == GMC_ACTIVE) && DSET_VALID_I && below_all &&
                    ((hits_r + 4'd1) >= need_hits);

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      hits_r <= 4'd0;
    end else if ((state_r != GMC_ACTIVE) || exit_hit) begin
      hits_r <= 4'd0;
    end else if (DSET_VALID_I) begin
      hits_r <= below_all ? hits_r + 4'd1 : 4'd0;
    end
  end

  // ========================================================================================
  // mode state machine
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      state_r <= GMC_IDLE;
    end else begin
      unique case (state_r)
        GMC_IDLE: begin
          if ((wr_ctrl && REG_WDATA_I[`GMC_BIT_MODE]) || entry_hit) begin
            state_r <= GMC_ACTIVE;
          end
        end
        GMC_ACTIVE: begin
          if (wr_ctrl && !REG_WDATA_I[`GMC_BIT_MODE]) begin
            state_r <= GMC_EXITING;
          end else if (exit_hit && !wr_ctrl) begin
            state_r <= GMC_IDLE;
          end
        end
        GMC_EXITING: begin
          if (wr_ctrl && REG_WDATA_I[`GMC_BIT_MODE]) begin
            state_r <= GMC_ACTIVE;
          end else if (!CONV_BUSY_I) begin
            state_r <= GMC_IDLE;
          end
        end
        default: state_r <= GMC_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      MOTION_MODE_O <= 1'b0;
    end else begin
      MOTION_MODE_O <= in_mode;
    end
  end

  // ========================================================================================
  // fifo level and flags; a full fifo drops the new dataset
  logic push;
  logic pop;
  logic full;
  gmc_byte_t irq_need;

  assign full = (level_r >= 8'(FIFO_DEPTH));
  assign push = in_mode && DSET_VALID_I && !full;
  assign pop  = DSET_READ_I && (level_r != 8'h00);

  // level up on append, down on read
  always_comb begin
    level_nxt = level_r;
    if (push && !pop) begin
      level_nxt = level_r + 8'h01;
    end else if (pop && !push) begin
      level_nxt = level_r - 8'h01;
    end
  end

  always_comb begin
    unique case (FIFO_IRQ_LEVEL_I)
      2'd0: irq_need = `GMC_LEVEL_0;
      2'd1: irq_need = `GMC_LEVEL_1;
      2'd2: irq_need = `GMC_LEVEL_2;
      2'd3: irq_need = `GMC_LEVEL_3;
    endcase
  end

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      level_r     <= 8'h00;
      FIFO_PUSH_O <= 1'b0;
    end else begin
      level_r     <= level_nxt;
      FIFO_PUSH_O <= push;
    end
  end

  logic valid_set;
  assign valid_set = (level_nxt >= irq_need);

  // valid clears only with empty fifo and mode over; set wins
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      FIFO_VALID_O <= 1'b0;
    end else if (valid_set) begin
      FIFO_VALID_O <= 1'b1;
    end else if ((level_nxt == 8'h00) && !in_mode) begin
      FIFO_VALID_O <= 1'b0;
    end
  end

  // irq only enabled, first one waits for level
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      MOTION_IRQ_O <= 1'b0;
    end else if (!irq_en_r || (level_nxt == 8'h00)) begin
      MOTION_IRQ_O <= 1'b0;
    end else if (valid_set) begin
      MOTION_IRQ_O <= 1'b1;
    end
  end

  // overflow sticky until fifo drains; set wins
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      FIFO_OVERFLOW_O <= 1'b0;
    end else if (level_nxt >= 8'(FIFO_DEPTH)) begin
      FIFO_OVERFLOW_O <= 1'b1;
    end else if (level_nxt == 8'h00) begin
      FIFO_OVERFLOW_O <= 1'b0;
    end
  end

  // ========================================================================================
  // assertions
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);

  // helper: cycles between ticks and the period expected at the first
  logic [PW-1:0] gap_r;
  logic [PW-1:0] exp_r;
  logic          armed_r;
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      gap_r   <= '0;
      exp_r   <= '0;
      armed_r <= 1'b0;
    end else begin
      armed_r <= (state_r == GMC_ACTIVE) && (tick || armed_r);
      gap_r   <= tick ? PW'(1) : gap_r + PW'(1);
      if (tick) begin
        exp_r <= per_load + PW'(1);
      end
    end
  end

  sequence s_exit_requested;
    wr_ctrl && !REG_WDATA_I[`GMC_BIT_MODE] && (state_r == GMC_ACTIVE);
  endsequence
  sequence s_conv_done;
    !CONV_BUSY_I && !wr_ctrl;
  endsequence

  a_tick_period: assert property (tick && armed_r |-> gap_r == exp_r)
    else $error("sample tick spacing wrong");
  a_irq_gated: assert property (!irq_en_r |=> !MOTION_IRQ_O)
    else $error("interrupt raised while disabled");
  a_irq_level: assert property ($rose(MOTION_IRQ_O) |-> $past(valid_set))
    else $error("interrupt before fifo level reached");
  a_force_entry: assert property (wr_ctrl && REG_WDATA_I[0] |=> ##1 MOTION_MODE_O)
    else $error("forced entry did not take");
  a_sw_exit: assert property (s_exit_requested ##1 s_conv_done |=> !in_mode)
    else $error("software exit not completed");
  a_sw_exit_wait: assert property ((state_r == GMC_EXITING) && CONV_BUSY_I && !wr_ctrl
                                   |=> in_mode)
    else $error("exit before conversion done");
  a_entry_cmp: assert property (!in_mode && entry_hit |=> state_r == GMC_ACTIVE)
    else $error("entry threshold ignored");
  a_no_entry: assert property (!in_mode && !ENGINE_EN_I && !wr_ctrl |=> !in_mode)
    else $error("entry while engine disabled");
  a_level_cap: assert property (level_r <= 8'(FIFO_DEPTH))
    else $error("fifo level above capacity");
  a_level_push: assert property (push && !pop |=> level_r == $past(level_r) + 8'h01)
    else $error("level not incremented on append");
  a_irq_clear: assert property (MOTION_IRQ_O |-> level_r != 8'h00)
    else $error("interrupt held with empty fifo");
  a_overflow: assert property (in_mode && DSET_VALID_I && full && !pop
                               |=> FIFO_OVERFLOW_O)
    else $error("overflow not flagged");

endmodule : gmc_top

// [hdl/gmc_defs.svh]
// register map, field positions, reset values and timing counts of the motion mode control
// ==========================================================================================
// Summary of operation
// - sample period is 88us times (setting plus one)
// - eight-bit sample setting resets to 0x0A
// - one sample tick on entry, then one per elapsed sample period
// - irq enable bit 1 gates every interrupt
// - first interrupt waits for fifo level threshold
// - control bit 0 reads back motion mode
// - motion mode samples at rate, appends datasets
// - writing 1 forces motion mode entry
// - writing 0 exits after current conversion
// - enabled engine enters when result exceeds threshold
// - in mode, channels compared against exit threshold
// - exit conditions are software selectable
// - proximity persistence ignored for entry
// - entry threshold at 0xB6 low, 0xB7 high
// - exit threshold at 0xB8 low, 0xB9 high
// - read-only fifo level counts unread datasets
// - exit persistence needs 1, 2, 4, 8 hits
// - fifo irq level selects 1, 4, 8, 16
// - irq clears when empty; valid also needs exit
// - overflow flag set when fifo reaches capacity
`ifndef GMC_DEFS_SVH
`define GMC_DEFS_SVH

// ==========================================================================================
// register offsets
`define GMC_OFS_SAMPLE_PERIOD 8'hB4
`define GMC_OFS_CONTROL       8'hB5
`define GMC_OFS_ENTRY_LO      8'hB6
`define GMC_OFS_ENTRY_HI      8'hB7
`define GMC_OFS_EXIT_LO       8'hB8
`define GMC_OFS_EXIT_HI       8'hB9
`define GMC_OFS_FIFO_LEVEL    8'hBA

// ==========================================================================================
// fields and reset values
`define GMC_BIT_MODE          0
`define GMC_BIT_IRQ_EN        1
`define GMC_RST_SAMPLE_PERIOD 8'h0A
`define GMC_RST_BYTE          8'h00
`define GMC_RD_UNMAPPED       8'h00

// ==========================================================================================
// timing: one sample unit in ns, clock period in ns
`define GMC_UNIT_NS           88000
`define GMC_CLK_NS            40
`define GMC_UNIT_CYC          (`GMC_UNIT_NS / `GMC_CLK_NS)

// ==========================================================================================
// persistence and fifo irq level tables
`define GMC_PERSIST_0         4'h1
`define GMC_PERSIST_1         4'h2
`define GMC_PERSIST_2         4'h4
`define GMC_PERSIST_3         4'h8
`define GMC_LEVEL_0           8'h01
`define GMC_LEVEL_1           8'h04
`define GMC_LEVEL_2           8'h08
`define GMC_LEVEL_3           8'h10

`endif

// [hdl/gmc_pkg.sv]
// types shared by the motion mode control
package gmc_pkg;

  // ========================================================================================
  // motion mode states
  typedef enum logic [1:0] {
    GMC_IDLE,
    GMC_ACTIVE,
    GMC_EXITING
  } gmc_state_t;

  typedef logic [7:0]  gmc_byte_t;
  typedef logic [15:0] gmc_word_t;

endpackage : gmc_pkg

// [verification/tb_top.sv]
// self-checking bench for the motion mode control
`include "gmc_defs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import gmc_pkg::*;
  localparam int UNIT  = 4;
  localparam int DEPTH = 32;
  localparam gmc_word_t HI = 16'h0200;
  localparam gmc_word_t LO = 16'h0050;
  localparam gmc_word_t NH = 16'hFFFF;
  logic       clk, rst, wr, rd, en, pv, busy, dv, drd;
  logic       tick, push, mode, irq, valid, ovf;
  logic [7:0] addr;
  logic [1:0] pers, lvl_code;
  logic [3:0] ign;
  gmc_byte_t  wdata, rdata, d;
  gmc_word_t  prox, ch_n, ch_o;
  int         err_count, check_count, n;
  int         lv_tab[4] = '{1, 4, 8, 16};
  gmc_byte_t  map_tab[5] = '{8'h34, 8'h12, 8'h00, 8'h01, 8'h00};

  gmc_top #(.UNIT_CYC(UNIT), .FIFO_DEPTH(DEPTH)) dut (
    .CLK_SYS_I(clk), .RST_I(rst), .REG_ADDR_I(addr), .REG_WR_I(wr),
    .REG_WDATA_I(wdata), .REG_RD_I(rd), .REG_RDATA_O(rdata),
    .ENGINE_EN_I(en), .EXIT_PERSIST_I(pers), .EXIT_IGNORE_I(ign),
    .FIFO_IRQ_LEVEL_I(lvl_code), .PROX_VALID_I(pv), .PROX_RESULT_I(prox),
    .CONV_BUSY_I(busy), .DSET_VALID_I(dv), .CH_NORTH_I(ch_n), .CH_SOUTH_I(ch_o),
    .CH_WEST_I(ch_o), .CH_EAST_I(ch_o), .DSET_READ_I(drd),
    .SAMPLE_TICK_O(tick), .FIFO_PUSH_O(push), .MOTION_MODE_O(mode),
    .MOTION_IRQ_O(irq), .FIFO_VALID_O(valid), .FIFO_OVERFLOW_O(ovf)
  );

  always #20 clk = ~clk;

  // ==========================================================================================
  // reporting
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test

  task automatic chk8(input gmc_byte_t got, input gmc_byte_t exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk1

  task automatic chk_n(input int got, input int exp);
    check_count++;
    if (got != exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_n

  // ==========================================================================================
  // access tasks: each starts and ends on a falling edge, strobes last one cycle
  task automatic reg_wr(input logic [7:0] a, input gmc_byte_t v);
    @(negedge clk);
    addr  = a;
    wdata = v;
    wr    = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, output gmc_byte_t v);
    @(negedge clk);
    addr = a;
    rd   = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    v  = rdata;
  endtask : reg_rd

  task automatic dset(input gmc_word_t nv, input gmc_word_t ov, input logic exp_push);
    @(negedge clk);
    ch_n = nv;
    ch_o = ov;
    dv   = 1'b1;
    @(negedge clk);
    dv = 1'b0;
    chk1(push, exp_push);
  endtask : dset

  // ends one cycle late so the registered mode output has caught up
  task automatic prox_in(input gmc_word_t v);
    @(negedge clk);
    prox = v;
    pv   = 1'b1;
    @(negedge clk);
    pv = 1'b0;
    @(negedge clk);
  endtask : prox_in

  task automatic drain;
    gmc_byte_t l;
    reg_rd(`GMC_OFS_FIFO_LEVEL, l);
    repeat (l) begin
      @(negedge clk);
      drd = 1'b1;
      @(negedge clk);
      drd = 1'b0;
    end
    reg_rd(`GMC_OFS_FIFO_LEVEL, l);
    chk8(l, 8'h00);
  endtask : drain

  // bounded: a missing tick ends the run instead of hanging it
  task automatic wait_tick(output int cnt);
    cnt = 0;
    do begin
      @(negedge clk);
      cnt++;
    end while (tick !== 1'b1 && cnt < 2000);
    if (cnt >= 2000) begin
      err_count++;
      finish_test();
    end
  endtask : wait_tick

  // ==========================================================================================
  // main sequence
  initial begin
    clk = 1'b0; rst = 1'b1; wr = 1'b0; rd = 1'b0; en = 1'b0; pv = 1'b0;
    busy = 1'b0; dv = 1'b0; drd = 1'b0; addr = 8'h00; wdata = 8'h00;
    pers = 2'd0; lvl_code = 2'd0; ign = 4'h0; prox = 16'h0000;
    ch_n = NH; ch_o = NH; err_count = 0; check_count = 0;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    reg_rd(`GMC_OFS_SAMPLE_PERIOD, d);
    chk8(d, `GMC_RST_SAMPLE_PERIOD);
    // control, thresholds, level and one unmapped place all read zero
    for (int i = 0; i < 7; i++) begin
      reg_rd(`GMC_OFS_CONTROL + i[7:0], d);
      chk8(d, 8'h00);
    end
    reg_wr(`GMC_OFS_ENTRY_LO, 8'h34);
    reg_wr(`GMC_OFS_ENTRY_HI, 8'h12);
    reg_wr(`GMC_OFS_EXIT_LO, 8'h00);
    reg_wr(`GMC_OFS_EXIT_HI, 8'h01);
    reg_wr(`GMC_OFS_FIFO_LEVEL, 8'h55);
    for (int i = 0; i < 5; i++) begin
      reg_rd(`GMC_OFS_ENTRY_LO + i[7:0], d);
      chk8(d, map_tab[i]);
    end
    // entry compare: disabled engine, equal value, then one above
    prox_in(16'h2000);
    chk1(mode, 1'b0);
    en = 1'b1;
    prox_in(16'h1234);
    chk1(mode, 1'b0);
    prox_in(16'h1235);
    chk1(mode, 1'b1);
    reg_rd(`GMC_OFS_CONTROL, d);
    chk8(d, 8'h01);
    wait_tick(n);
    wait_tick(n);
    chk_n(n, 11 * UNIT);
    // short period: host keeps pulse settings at their minimum
    reg_wr(`GMC_OFS_SAMPLE_PERIOD, 8'h02);
    wait_tick(n);
    wait_tick(n);
    chk_n(n, 3 * UNIT);
    dset(NH, NH, 1'b1);
    chk1(valid, 1'b1);
    chk1(irq, 1'b0);
    drain();
    reg_wr(`GMC_OFS_CONTROL, 8'h03);
    for (int c = 0; c < 4; c++) begin
      lvl_code = c[1:0];
      repeat (lv_tab[c] - 1) dset(NH, NH, 1'b1);
      chk1(irq, 1'b0);
      dset(NH, NH, 1'b1);
      chk1(irq, 1'b1);
      drain();
      chk1(irq, 1'b0);
      chk1(valid, 1'b1);
    end
    // software exit waits for the conversion in flight
    busy = 1'b1;
    reg_wr(`GMC_OFS_CONTROL, 8'h00);
    repeat (4) @(negedge clk);
    chk1(mode, 1'b1);
    busy = 1'b0;
    repeat (2) @(negedge clk);
    chk1(mode, 1'b0);
    chk1(valid, 1'b0);
    // exit persistence, north ignored while held high, one breaker mid-run
    ign = 4'b0001;
    for (int p = 0; p < 4; p++) begin
      pers = p[1:0];
      reg_wr(`GMC_OFS_CONTROL, 8'h01);
      repeat ((1 << p) - 1) dset(NH, LO, 1'b1);
      dset(LO, HI, 1'b1);
      repeat ((1 << p) - 1) dset(NH, LO, 1'b1);
      @(negedge clk);
      chk1(mode, 1'b1);
      dset(NH, LO, 1'b1);
      @(negedge clk);
      chk1(mode, 1'b0);
    end
    drain();
    reg_wr(`GMC_OFS_CONTROL, 8'h01);
    repeat (DEPTH - 1) dset(NH, NH, 1'b1);
    chk1(ovf, 1'b0);
    dset(NH, NH, 1'b1);
    chk1(ovf, 1'b1);
    dset(NH, NH, 1'b0);
    reg_rd(`GMC_OFS_FIFO_LEVEL, d);
    chk8(d, 8'h20);
    drain();
    chk1(ovf, 1'b0);
    // exit with no conversion in flight
    reg_wr(`GMC_OFS_CONTROL, 8'h00);
    repeat (2) @(negedge clk);
    chk1(mode, 1'b0);
    chk1(valid, 1'b0);
    dset(NH, NH, 1'b0);
    finish_test();
  end
endmodule : tb_top
